// >>> dv/dss_path_model.sv
// Word source for one low-speed or high-speed data path
`timescale 1ns/1ps
`include "dss_defines.vh"
module dss_path_model (
    input wire clk,
    input wire [1:0] kind,
    output reg [31:0] data,
    output reg [3:0] ctrl
);
    reg [23:0] cnt_ff = 24'h000000;
    // Moves every cycle so a stale word never passes for a fresh one
    always @(negedge clk) begin
        cnt_ff <= cnt_ff + 24'h000001;
    end
    always @* begin
        data = {cnt_ff, 8'h3c};
        ctrl = 4'h0;
        case (kind)
            2'h1: begin
                data = `DSS_KR_IDLE_DATA;
                ctrl = `DSS_KR_IDLE_CTRL;
            end
            2'h2: begin
                data = `DSS_KR_LF_DATA;
                ctrl = `DSS_KR_LF_CTRL;
            end
            2'h3: begin
                data = {16'h0000, `DSS_KX_I1_D, `DSS_KX_COMMA};
                ctrl = 4'h1;
            end
            default: ;
        endcase
    end
endmodule

// >>> dv/dss_top_assertions.sv
// Port-level checks of the data switch source control
`timescale 1ns/1ps
`include "dss_defines.vh"
module dss_top_assertions (
    input wire clk,
    input wire rst,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    input wire [15:0] reg_rdata_ff,
    input wire reg_rvalid_ff,
    input wire [1:0] chan_mode,
    input wire [31:0] tx_low_speed_data,
    input wire [3:0] tx_low_speed_ctrl,
    input wire [31:0] tx_high_speed_data,
    input wire [3:0] tx_high_speed_ctrl,
    input wire [31:0] tx_out_data,
    input wire [3:0] tx_out_ctrl,
    input wire [31:0] rx_low_speed_data,
    input wire [3:0] rx_low_speed_ctrl,
    input wire [31:0] rx_high_speed_data,
    input wire [3:0] rx_high_speed_ctrl,
    input wire [31:0] rx_out_data,
    input wire [3:0] rx_out_ctrl
);
    reg [15:0] shadow_ff [0:3];
    // 0x17..0x1a map onto entries 0..3
    wire [1:0] idx = reg_addr[1:0] + 2'h1;
    wire ctl_hit = reg_addr >= 16'h0017 && reg_addr <= 16'h001a;
    wire [15:0] shadow_sel = shadow_ff[idx];
    wire [35:0] tx_lo = {tx_low_speed_ctrl, tx_low_speed_data};
    wire [35:0] tx_hi = {tx_high_speed_ctrl, tx_high_speed_data};
    wire [35:0] tx_o = {tx_out_ctrl, tx_out_data};
    wire [35:0] rx_lo = {rx_low_speed_ctrl, rx_low_speed_data};
    wire [35:0] rx_hi = {rx_high_speed_ctrl, rx_high_speed_data};
    wire [35:0] rx_o = {rx_out_ctrl, rx_out_data};
    always @(posedge clk) begin
        if (rst) begin
            shadow_ff[0] <= `DSS_RST_TX_CTRL_A;
            shadow_ff[1] <= `DSS_RST_TX_CTRL_B;
            shadow_ff[2] <= `DSS_RST_RX_CTRL_A;
            shadow_ff[3] <= `DSS_RST_RX_CTRL_B;
        end else if (reg_wr && ctl_hit) begin
            shadow_ff[idx] <= reg_wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid_ff)
        else $error("read answer missing");
    AST_RVALID_ONLY: assert property (!reg_rd |=> !reg_rvalid_ff)
        else $error("read answer without a read");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (reg_rd && (reg_addr < 16'h0017 ||
        reg_addr > 16'h001b) |=> reg_rdata_ff == 16'h0000)
        else $error("unmapped read not zero");
    AST_CTRL_READBACK: assert property (reg_rd && !reg_wr && ctl_hit
        |=> reg_rdata_ff == $past(shadow_sel))
        else $error("control register readback wrong");
    AST_STATUS_ONEHOT: assert property (reg_rd && reg_addr == 16'h001b
        |=> $onehot(reg_rdata_ff[15:12]) && $onehot(reg_rdata_ff[7:4]))
        else $error("source status not one-hot");
    AST_PEND_DONE: assert property (reg_rd && reg_addr == 16'h001b |=>
        !(reg_rdata_ff[11] && reg_rdata_ff[10]) && !(reg_rdata_ff[3] && reg_rdata_ff[2]))
        else $error("pending and done both set");
    AST_PLAIN_STUFF: assert property (!$past(rst) && $past(chan_mode) != `DSS_CHAN_KR &&
        $past(chan_mode) != `DSS_CHAN_KX |-> tx_o == $past(tx_lo) || tx_o == $past(tx_hi)
        || tx_o == {`DSS_KR_IDLE_CTRL, `DSS_KR_IDLE_DATA})
        else $error("tx output outside plain mode set");
    AST_KR_STUFF: assert property (!$past(rst) && $past(chan_mode) == `DSS_CHAN_KR
        |-> tx_o == $past(tx_lo) || tx_o == $past(tx_hi) || tx_o == 36'hf07070707
        || tx_o == {`DSS_KR_LF_CTRL, `DSS_KR_LF_DATA})
        else $error("tx output outside KR set");
    AST_KX_STUFF: assert property (!$past(rst) && $past(chan_mode) == `DSS_CHAN_KX
        |-> rx_o == $past(rx_lo) || rx_o == $past(rx_hi) || rx_o == 36'h1000050bc
        || rx_o == 36'h1000000fe)
        else $error("rx output outside KX set");
    COV_STATUS: cover property (reg_rd && reg_addr == 16'h001b);
    COV_KR_LF: cover property (tx_o == {`DSS_KR_LF_CTRL, `DSS_KR_LF_DATA});
    COV_KX_I2: cover property (rx_o == 36'h1000050bc);
endmodule
bind dss_top dss_top_assertions u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .chan_mode(chan_mode),
    .tx_low_speed_data(tx_low_speed_data), .tx_low_speed_ctrl(tx_low_speed_ctrl),
    .tx_high_speed_data(tx_high_speed_data), .tx_high_speed_ctrl(tx_high_speed_ctrl),
    .tx_out_data(tx_out_data), .tx_out_ctrl(tx_out_ctrl),
    .rx_low_speed_data(rx_low_speed_data), .rx_low_speed_ctrl(rx_low_speed_ctrl),
    .rx_high_speed_data(rx_high_speed_data), .rx_high_speed_ctrl(rx_high_speed_ctrl),
    .rx_out_data(rx_out_data), .rx_out_ctrl(rx_out_ctrl));

// >>> dv/test_dss_top.sv
// Self-checking bench for the data switch source control
`timescale 1ns/1ps
`include "dss_defines.vh"
module test_dss_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg reg_wr = 1'b0, reg_rd = 1'b0, pin = 1'b0, pen = 1'b0, ptg = 1'b0;
    reg [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000;
    reg [1:0] chan_mode = `DSS_CHAN_KR;
    reg [1:0] k_tl = 2'h0, k_th = 2'h0, k_rl = 2'h0, k_rh = 2'h0;
    wire [31:0] tl_d, th_d, rl_d, rh_d, tx_out_data, rx_out_data;
    wire [3:0] tl_c, th_c, rl_c, rh_c, tx_out_ctrl, rx_out_ctrl;
    wire [15:0] reg_rdata_ff;
    wire reg_rvalid_ff;
    integer fail_count = 0, check_count = 0, n, i;
    always #2 clk = ~clk;
    dss_path_model u_tl (.clk(clk), .kind(k_tl), .data(tl_d), .ctrl(tl_c));
    dss_path_model u_th (.clk(clk), .kind(k_th), .data(th_d), .ctrl(th_c));
    dss_path_model u_rl (.clk(clk), .kind(k_rl), .data(rl_d), .ctrl(rl_c));
    dss_path_model u_rh (.clk(clk), .kind(k_rh), .data(rh_d), .ctrl(rh_c));
    dss_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .chan_mode(chan_mode), .port_address_bit0_pin(pin),
        .port_pin_function_enable(pen), .port_pin_function_target(ptg),
        .tx_off_char(8'haa), .tx_on_char(8'h55), .rx_off_char(8'haa), .rx_on_char(8'h55),
        .tx_low_speed_data(tl_d), .tx_low_speed_ctrl(tl_c), .tx_high_speed_data(th_d),
        .tx_high_speed_ctrl(th_c), .tx_out_data(tx_out_data), .tx_out_ctrl(tx_out_ctrl),
        .rx_low_speed_data(rl_d), .rx_low_speed_ctrl(rl_c), .rx_high_speed_data(rh_d),
        .rx_high_speed_ctrl(rh_c), .rx_out_data(rx_out_data), .rx_out_ctrl(rx_out_ctrl));
    task test_done;
        begin
            if (fail_count == 0 && check_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task check(input string name, input [35:0] seen, input [35:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
            end
        end
    endtask
    // All bus tasks start and end at a falling edge
    task reg_write(input [15:0] a, input [15:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk);
            reg_wr = 1'b0;
            // Quiet edge so a following call never re-raises the strobe at once
            @(negedge clk);
        end
    endtask
    task reg_read(input [15:0] a, output [15:0] d);
        integer j;
        begin
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk);
            reg_rd = 1'b0;
            for (j = 0; j < 4 && reg_rvalid_ff !== 1'b1; j = j + 1)
                @(negedge clk);
            check("rvalid", reg_rvalid_ff, 1'b1);
            d = reg_rdata_ff;
            @(negedge clk);
        end
    endtask
    task read_check(input [15:0] a, input [15:0] exp);
        reg [15:0] d;
        begin
            reg_read(a, d);
            check("register", d, exp);
        end
    endtask
    // Polls status, bounded, since the switch waits on data patterns
    task st_wait(input [15:0] exp);
        reg [15:0] s;
        integer j;
        begin
            s = 16'h0000;
            for (j = 0; j < 30 && s !== exp; j = j + 1)
                reg_read(16'h001b, s);
            check("status", s, exp);
        end
    endtask
    task count_word(input is_rx, input [35:0] w);
        begin
            n = 0;
            for (i = 0; i < 40; i = i + 1) begin
                @(negedge clk);
                if ((is_rx ? {rx_out_ctrl, rx_out_data} : {tx_out_ctrl, tx_out_data}) === w)
                    n = n + 1;
            end
        end
    endtask
    task t_reset;
        begin
            read_check(16'h0017, 16'h2000);
            read_check(16'h0018, 16'h0c20);
            read_check(16'h0019, 16'h2500);
            read_check(16'h001a, 16'h4c20);
            reg_write(16'h001b, 16'hffff);
            reg_write(16'h0030, 16'hffff);
            read_check(16'h001b, 16'h1020);
            read_check(16'h0030, 16'h0000);
        end
    endtask
    task t_tx_kr;
        begin
            reg_write(16'h0017, 16'h2060);
            reg_write(16'h0018, 16'h4c02);
            st_wait(16'h1820);
            check("tx_pass", {tx_out_ctrl, tx_out_data[7:0]}, 12'h03c);
            k_tl = 2'h1;
            st_wait(16'h1920);
            check("tx_stuff", {tx_out_ctrl, tx_out_data}, 36'h10100009c);
            k_th = 2'h2;
            st_wait(16'h2720);
            k_th = 2'h0;
            k_tl = 2'h0;
            repeat (3) @(negedge clk);
            check("tx_new", {tx_out_ctrl, tx_out_data[7:0]}, 12'h03c);
        end
    endtask
    task t_rx_kx;
        begin
            chan_mode = `DSS_CHAN_KX;
            reg_write(16'h0019, 16'h2000);
            reg_write(16'h001a, 16'h2c03);
            count_word(1'b1, {4'h1, 16'h0000, `DSS_KX_I2_D, `DSS_KX_COMMA});
            check("rx_mask", n, 4);
            st_wait(16'h2717);
        end
    endtask
    task t_rx_pin;
        reg [4:0] pv, ev, tv, hv;
        integer j;
        begin
            pv = 5'b10111;
            ev = 5'b01111;
            tv = 5'b11101;
            hv = 5'b00101;
            reg_write(16'h0019, 16'h3400);
            for (j = 0; j < 5; j = j + 1) begin
                pin = pv[j];
                pen = ev[j];
                ptg = tv[j];
                st_wait({12'h27 << 4, 4'h0} | (hv[j] ? 16'h0027 : 16'h0017));
            end
            reg_write(16'h0019, 16'h2000);
            st_wait(16'h2717);
        end
    endtask
    task t_plain;
        begin
            chan_mode = 2'b00;
            reg_write(16'h0018, 16'h0c01);
            count_word(1'b0, {`DSS_KR_IDLE_CTRL, `DSS_KR_IDLE_DATA});
            check("tx_mask", n, 2);
            st_wait(16'h1717);
        end
    endtask
    task t_tx_pin;
        begin
            pen = 1'b1;
            ptg = 1'b0;
            pin = 1'b1;
            reg_write(16'h0017, 16'h3400);
            st_wait(16'h2717);
            pin = 1'b0;
            st_wait(16'h1717);
        end
    endtask
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_tx_kr;
        t_rx_kx;
        t_rx_pin;
        t_plain;
        t_tx_pin;
        test_done;
    end
    // About 200 cycles expected; cut off well beyond that
    initial begin
        #80000;
        fail_count = fail_count + 1;
        test_done;
    end
endmodule

// >>> logic/dss_defines.vh
// Register map, field positions, reset values and pattern codes for the data switch
`ifndef DSS_DEFINES_VH
`define DSS_DEFINES_VH

`define DSS_ADDR_TX_CTRL_A 16'h0017
`define DSS_ADDR_TX_CTRL_B 16'h0018
`define DSS_ADDR_RX_CTRL_A 16'h0019
`define DSS_ADDR_RX_CTRL_B 16'h001a
`define DSS_ADDR_STATUS 16'h001b

`define DSS_RST_TX_CTRL_A 16'h2000
`define DSS_RST_TX_CTRL_B 16'h0c20
`define DSS_RST_RX_CTRL_A 16'h2500
`define DSS_RST_RX_CTRL_B 16'h4c20

// Control register A fields
`define DSS_PIN_EN_BIT 12
`define DSS_PIN_HI_MSB 11
`define DSS_PIN_HI_LSB 10
`define DSS_PIN_LO_MSB 9
`define DSS_PIN_LO_LSB 8
`define DSS_OFF_SEL_BIT 7
`define DSS_ON_SEL_BIT 6
`define DSS_STUFF_SEL_BIT 5
// Control register B fields
`define DSS_SRC_MSB 15
`define DSS_SRC_LSB 14
`define DSS_MODE_MSB 13
`define DSS_MODE_LSB 12
`define DSS_MASK_MSB 7
`define DSS_MASK_LSB 0

// Source codes and one-hot source status
`define DSS_SRC_LOW 2'b00
`define DSS_SRC_HIGH 2'b01
`define DSS_ONEHOT_LOW 4'b0001
`define DSS_ONEHOT_HIGH 4'b0010

// Channel operating modes
`define DSS_CHAN_KR 2'b01
`define DSS_CHAN_KX 2'b10

// Word patterns: 4 lanes, ctrl bit per lane
`define DSS_KR_IDLE_DATA 32'h07070707
`define DSS_KR_IDLE_CTRL 4'hf
`define DSS_KR_LF_DATA 32'h0100009c
`define DSS_KR_LF_CTRL 4'h1
`define DSS_KX_COMMA 8'hbc
`define DSS_KX_I1_D 8'hc5
`define DSS_KX_I2_D 8'h50
`define DSS_KX_ERR 8'hfe

`endif

// >>> logic/dss_switch.v
// One direction of the data switch: trigger detect, stuff masking, source change
`timescale 1ns/1ps
`include "dss_defines.vh"

module dss_switch #(
    parameter RESET_HIGH = 1'b0
) (
    input wire clk,
    input wire rst,
    input wire [31:0] low_speed_data,
    input wire [3:0] low_speed_ctrl,
    input wire [31:0] high_speed_data,
    input wire [3:0] high_speed_ctrl,
    input wire [1:0] chan_mode,
    input wire want_high,
    input wire want_valid,
    input wire [1:0] trigger_mode,
    input wire off_sel,
    input wire on_sel,
    input wire stuff_sel,
    input wire [7:0] mask_length,
    input wire [7:0] off_char,
    input wire [7:0] on_char,
    output reg [31:0] out_data_ff,
    output reg [3:0] out_ctrl_ff,
    output reg [3:0] src_onehot_ff,
    output reg pending_ff,
    output reg done_ff,
    output reg on_flag_ff,
    output reg off_flag_ff
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_WOFF = 4'b0010;
    localparam ST_MASK = 4'b0100;
    localparam ST_WON = 4'b1000;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg cur_high_ff;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;
    wire pattern_mode;
    wire off_any;
    wire on_any;
    wire [31:0] old_data;
    wire [3:0] old_ctrl;
    wire [31:0] new_data;
    wire [3:0] new_ctrl;
    wire off_hit;
    wire on_hit;
    reg [31:0] stuff_data;
    reg [3:0] stuff_ctrl;

    // Pattern selections only apply in KR or KX
    assign pattern_mode = (chan_mode == `DSS_CHAN_KR) || (chan_mode == `DSS_CHAN_KX);
    assign off_any = trigger_mode[0] ^ trigger_mode[1];
    assign on_any = trigger_mode[1];
    assign old_data = cur_high_ff ? high_speed_data : low_speed_data;
    assign old_ctrl = cur_high_ff ? high_speed_ctrl : low_speed_ctrl;
    assign new_data = cur_high_ff ? low_speed_data : high_speed_data;
    assign new_ctrl = cur_high_ff ? low_speed_ctrl : high_speed_ctrl;

    function match;
        input [31:0] d;
        input [3:0] c;
        input sel;
        input [7:0] ch;
        input kx;
        begin
            if (!kx) begin
                if (sel)
                    match = (d == `DSS_KR_LF_DATA) && (c == `DSS_KR_LF_CTRL);
                else
                    match = (d == `DSS_KR_IDLE_DATA) && (c == `DSS_KR_IDLE_CTRL);
            end else begin
                if (sel)
                    match = (d[7:0] == ch);
                else
                    match = (d[7:0] == `DSS_KX_COMMA) && (c[1:0] == 2'b01) &&
                        ((d[15:8] == `DSS_KX_I1_D) || (d[15:8] == `DSS_KX_I2_D));
            end
        end
    endfunction

    // Outside KR/KX the trigger patterns are meaningless, so any data passes
    assign off_hit = off_any || !pattern_mode ||
        match(old_data, old_ctrl, off_sel, off_char, chan_mode == `DSS_CHAN_KX);
    assign on_hit = on_any || !pattern_mode ||
        match(new_data, new_ctrl, on_sel, on_char, chan_mode == `DSS_CHAN_KX);

    // Stuff pattern choice
    always @* begin
        if (chan_mode == `DSS_CHAN_KX) begin
            stuff_data = stuff_sel ? {24'h000000, `DSS_KX_ERR} :
                {16'h0000, `DSS_KX_I2_D, `DSS_KX_COMMA};
            stuff_ctrl = stuff_sel ? 4'h1 : 4'h1;
        end else begin
            stuff_data = (stuff_sel && pattern_mode) ? `DSS_KR_LF_DATA : `DSS_KR_IDLE_DATA;
            stuff_ctrl = (stuff_sel && pattern_mode) ? `DSS_KR_LF_CTRL : `DSS_KR_IDLE_CTRL;
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (want_valid && (want_high != cur_high_ff))
                    nxt_state = ST_WOFF;
            end
            ST_WOFF: begin
                if (off_hit) begin
                    nxt_cnt = mask_length;
                    nxt_state = (mask_length == 8'h00) ? ST_WON : ST_MASK;
                end
            end
            ST_MASK: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (cnt_ff == 8'h01)
                    nxt_state = ST_WON;
            end
            ST_WON: begin
                if (on_hit)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
            cur_high_ff <= RESET_HIGH;
            out_data_ff <= 32'h00000000;
            out_ctrl_ff <= 4'h0;
            src_onehot_ff <= RESET_HIGH ? `DSS_ONEHOT_HIGH : `DSS_ONEHOT_LOW;
            pending_ff <= 1'b0;
            done_ff <= 1'b0;
            on_flag_ff <= 1'b0;
            off_flag_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            if (state_ff == ST_IDLE && nxt_state == ST_WOFF) begin
                pending_ff <= 1'b1;
                done_ff <= 1'b0;
                on_flag_ff <= 1'b0;
                off_flag_ff <= 1'b0;
            end
            if (state_ff == ST_WOFF && off_hit)
                off_flag_ff <= 1'b1;
            if (state_ff == ST_WON && on_hit) begin
                cur_high_ff <= ~cur_high_ff;
                src_onehot_ff <= cur_high_ff ? `DSS_ONEHOT_LOW : `DSS_ONEHOT_HIGH;
                on_flag_ff <= 1'b1;
                pending_ff <= 1'b0;
                done_ff <= 1'b1;
            end
            // Stuff from the OFF hit until ON; the word that meets ON passes
            if (state_ff == ST_MASK || (state_ff == ST_WON && !on_hit) ||
                (state_ff == ST_WOFF && off_hit)) begin
                out_data_ff <= stuff_data;
                out_ctrl_ff <= stuff_ctrl;
            end else if (state_ff == ST_WON) begin
                out_data_ff <= new_data;
                out_ctrl_ff <= new_ctrl;
            end else begin
                out_data_ff <= old_data;
                out_ctrl_ff <= old_ctrl;
            end
        end
    end
endmodule

// >>> logic/dss_top.v
// Data switch source control: registers, pin selection and both switch directions
`timescale 1ns/1ps
`include "dss_defines.vh"

// Overview of operation
// - Pin switch off: transmit source from software field, 00 low, 01 high.
// - Receive source from software field; 00 low, 01 high, resets high.
// - OFF: modes 00/11 wait for OFF pattern, 01/10 accept any data.
// - ON: modes 00/01 wait for ON pattern, 10/11 accept any data.
// - Output carries stuff pattern for programmed cycle count plus one, default 32.
// - Receive pin enable hands source choice to port address pin.
// - Receive pin mode: pin-high and pin-low source fields, both default high.
// - OFF select picks local fault or idle, or character match in KX.
// - ON select picks local fault or idle, or character match in KX.
// - Stuff select picks local fault/idle, or K30.7 versus /I2/ in KX.
// - Pattern selections only count in KR or KX modes.
// - Transmit pin enable likewise, pin fields default to low input.
// - Status shows pending, done, ON, OFF and one-hot source per direction.
module dss_top (
    input wire clk,
    input wire rst,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire reg_rd,
    output reg [15:0] reg_rdata_ff,
    output reg reg_rvalid_ff,
    input wire [1:0] chan_mode,
    input wire port_address_bit0_pin,
    input wire port_pin_function_enable,
    input wire port_pin_function_target,
    input wire [7:0] tx_off_char,
    input wire [7:0] tx_on_char,
    input wire [7:0] rx_off_char,
    input wire [7:0] rx_on_char,
    input wire [31:0] tx_low_speed_data,
    input wire [3:0] tx_low_speed_ctrl,
    input wire [31:0] tx_high_speed_data,
    input wire [3:0] tx_high_speed_ctrl,
    output wire [31:0] tx_out_data,
    output wire [3:0] tx_out_ctrl,
    input wire [31:0] rx_low_speed_data,
    input wire [3:0] rx_low_speed_ctrl,
    input wire [31:0] rx_high_speed_data,
    input wire [3:0] rx_high_speed_ctrl,
    output wire [31:0] rx_out_data,
    output wire [3:0] rx_out_ctrl
);
    reg [15:0] tx_ctrl_a_ff;
    reg [15:0] tx_ctrl_b_ff;
    reg [15:0] rx_ctrl_a_ff;
    reg [15:0] rx_ctrl_b_ff;
    reg pin_meta_ff;
    reg pin_sync_ff;
    wire [15:0] status_word;
    wire [1:0] tx_switch_source_select;
    wire [1:0] rx_switch_source_select;
    wire tx_pin_switch_enable;
    wire rx_pin_switch_enable;
    wire [1:0] tx_pin_high_source;
    wire [1:0] tx_pin_low_source;
    wire [1:0] rx_pin_high_source;
    wire [1:0] rx_pin_low_source;
    wire tx_pin_owned;
    wire rx_pin_owned;
    reg [1:0] tx_code;
    reg [1:0] rx_code;
    wire tx_want_valid;
    wire rx_want_valid;
    wire [3:0] tx_onehot;
    wire [3:0] rx_onehot;
    wire tx_pend;
    wire tx_done;
    wire tx_on;
    wire tx_off;
    wire rx_pend;
    wire rx_done;
    wire rx_on;
    wire rx_off;

    // Pin is asynchronous to clk
    always @(posedge clk) begin
        if (rst) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= port_address_bit0_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Register writes; reserved bits are stored as written
    always @(posedge clk) begin
        if (rst) begin
            tx_ctrl_a_ff <= `DSS_RST_TX_CTRL_A;
            tx_ctrl_b_ff <= `DSS_RST_TX_CTRL_B;
            rx_ctrl_a_ff <= `DSS_RST_RX_CTRL_A;
            rx_ctrl_b_ff <= `DSS_RST_RX_CTRL_B;
        end else if (reg_wr) begin
            case (reg_addr)
                `DSS_ADDR_TX_CTRL_A: tx_ctrl_a_ff <= reg_wdata;
                `DSS_ADDR_TX_CTRL_B: tx_ctrl_b_ff <= reg_wdata;
                `DSS_ADDR_RX_CTRL_A: rx_ctrl_a_ff <= reg_wdata;
                `DSS_ADDR_RX_CTRL_B: rx_ctrl_b_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    assign tx_switch_source_select = tx_ctrl_b_ff[`DSS_SRC_MSB:`DSS_SRC_LSB];
    assign rx_switch_source_select = rx_ctrl_b_ff[`DSS_SRC_MSB:`DSS_SRC_LSB];
    assign tx_pin_switch_enable = tx_ctrl_a_ff[`DSS_PIN_EN_BIT];
    assign rx_pin_switch_enable = rx_ctrl_a_ff[`DSS_PIN_EN_BIT];
    assign tx_pin_high_source = tx_ctrl_a_ff[`DSS_PIN_HI_MSB:`DSS_PIN_HI_LSB];
    assign tx_pin_low_source = tx_ctrl_a_ff[`DSS_PIN_LO_MSB:`DSS_PIN_LO_LSB];
    assign rx_pin_high_source = rx_ctrl_a_ff[`DSS_PIN_HI_MSB:`DSS_PIN_HI_LSB];
    assign rx_pin_low_source = rx_ctrl_a_ff[`DSS_PIN_LO_MSB:`DSS_PIN_LO_LSB];

    // Pin reads high only when its function is aimed at this direction
    assign tx_pin_owned = port_pin_function_enable && !port_pin_function_target;
    assign rx_pin_owned = port_pin_function_enable && port_pin_function_target;

    always @* begin
        if (tx_pin_switch_enable)
            tx_code = (pin_sync_ff && tx_pin_owned) ? tx_pin_high_source
                : tx_pin_low_source;
        else
            tx_code = tx_switch_source_select;
        if (rx_pin_switch_enable)
            rx_code = (pin_sync_ff && rx_pin_owned) ? rx_pin_high_source
                : rx_pin_low_source;
        else
            rx_code = rx_switch_source_select;
    end

    // Reserved codes request nothing; the switch holds its source
    assign tx_want_valid = (tx_code == `DSS_SRC_LOW) || (tx_code == `DSS_SRC_HIGH);
    assign rx_want_valid = (rx_code == `DSS_SRC_LOW) || (rx_code == `DSS_SRC_HIGH);

    dss_switch #(
        .RESET_HIGH(1'b0)
    ) u_tx_switch (
        .clk(clk),
        .rst(rst),
        .low_speed_data(tx_low_speed_data),
        .low_speed_ctrl(tx_low_speed_ctrl),
        .high_speed_data(tx_high_speed_data),
        .high_speed_ctrl(tx_high_speed_ctrl),
        .chan_mode(chan_mode),
        .want_high(tx_code[0]),
        .want_valid(tx_want_valid),
        .trigger_mode(tx_ctrl_b_ff[`DSS_MODE_MSB:`DSS_MODE_LSB]),
        .off_sel(tx_ctrl_a_ff[`DSS_OFF_SEL_BIT]),
        .on_sel(tx_ctrl_a_ff[`DSS_ON_SEL_BIT]),
        .stuff_sel(tx_ctrl_a_ff[`DSS_STUFF_SEL_BIT]),
        .mask_length(tx_ctrl_b_ff[`DSS_MASK_MSB:`DSS_MASK_LSB]),
        .off_char(tx_off_char),
        .on_char(tx_on_char),
        .out_data_ff(tx_out_data),
        .out_ctrl_ff(tx_out_ctrl),
        .src_onehot_ff(tx_onehot),
        .pending_ff(tx_pend),
        .done_ff(tx_done),
        .on_flag_ff(tx_on),
        .off_flag_ff(tx_off)
    );

    dss_switch #(
        .RESET_HIGH(1'b1)
    ) u_rx_switch (
        .clk(clk),
        .rst(rst),
        .low_speed_data(rx_low_speed_data),
        .low_speed_ctrl(rx_low_speed_ctrl),
        .high_speed_data(rx_high_speed_data),
        .high_speed_ctrl(rx_high_speed_ctrl),
        .chan_mode(chan_mode),
        .want_high(rx_code[0]),
        .want_valid(rx_want_valid),
        .trigger_mode(rx_ctrl_b_ff[`DSS_MODE_MSB:`DSS_MODE_LSB]),
        .off_sel(rx_ctrl_a_ff[`DSS_OFF_SEL_BIT]),
        .on_sel(rx_ctrl_a_ff[`DSS_ON_SEL_BIT]),
        .stuff_sel(rx_ctrl_a_ff[`DSS_STUFF_SEL_BIT]),
        .mask_length(rx_ctrl_b_ff[`DSS_MASK_MSB:`DSS_MASK_LSB]),
        .off_char(rx_off_char),
        .on_char(rx_on_char),
        .out_data_ff(rx_out_data),
        .out_ctrl_ff(rx_out_ctrl),
        .src_onehot_ff(rx_onehot),
        .pending_ff(rx_pend),
        .done_ff(rx_done),
        .on_flag_ff(rx_on),
        .off_flag_ff(rx_off)
    );

    assign status_word = {tx_onehot, tx_pend, tx_done, tx_on, tx_off,
        rx_onehot, rx_pend, rx_done, rx_on, rx_off};

    // Read answer one cycle after the strobe; unmapped reads return zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata_ff <= 16'h0000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `DSS_ADDR_TX_CTRL_A: reg_rdata_ff <= tx_ctrl_a_ff;
                    `DSS_ADDR_TX_CTRL_B: reg_rdata_ff <= tx_ctrl_b_ff;
                    `DSS_ADDR_RX_CTRL_A: reg_rdata_ff <= rx_ctrl_a_ff;
                    `DSS_ADDR_RX_CTRL_B: reg_rdata_ff <= rx_ctrl_b_ff;
                    `DSS_ADDR_STATUS: reg_rdata_ff <= status_word;
                    default: reg_rdata_ff <= 16'h0000;
                endcase
            end
        end
    end
endmodule
